// ==== design/homing_and_multistage_position.v ====
/*
  homing search and multistage position sequencer of a servo drive in position
  mode. drives a motion profile generator with speed, ramp, direction and
  target commands; stage records are loaded through a plain write port.
  assumes all inputs synchronous to CORE_CLK and a profile generator that
  pulses MOTION_DONE when a commanded move has finished.
*/
// Notes on behaviour
// - homing only in position control mode
// - fast search, decelerate on reference rising edge
// - slow reverse search, stop on falling edge
// - homing timeout raises an error
// - post action: run program now or not
// - homing trigger: off, input, auto after power-up
// - search direction and switch or index reference
// - start input low: unhomed, stage commands ignored
// - sixteen stored stage parameter groups
// - motion only from stored stages, no pulses
// - run while servo on, stop when off
// - resume at stage n+1 or stage 1
// - single sequence runs once per enable
// - four operation modes select sequencing
// - input mode: one stage per enable rise
// - displacement relative or absolute from origin
// - wait times in ms or seconds
`timescale 1ns/1ns
`include "homing_and_multistage_position_regs.vh"

module homing_and_multistage_position #(
    parameter CYCLES_PER_MS = `MS_PERIOD_NS / `CLK_PERIOD_NS,
    parameter SPEED_W       = 16,
    parameter TIME_W        = 16,
    parameter DISP_W        = 32
) (
    input  wire               CORE_CLK,
    input  wire               RESET,
    input  wire [3:0]         CONTROL_MODE_SELECT,
    input  wire               HOMING_POST_ACTION,
    input  wire [1:0]         HOMING_ENABLE_SELECT,
    input  wire [1:0]         HOMING_SEARCH_MODE,
    input  wire [SPEED_W-1:0] HOMING_HIGH_SPEED,
    input  wire [SPEED_W-1:0] HOMING_LOW_SPEED,
    input  wire [TIME_W-1:0]  HOMING_DECEL_TIME,
    input  wire [TIME_W-1:0]  HOMING_TIMEOUT,
    input  wire               RESIDUAL_COMMAND_MODE,
    input  wire [1:0]         STAGE_OPERATION_MODE,
    input  wire [4:0]         EFFECTIVE_STAGES,
    input  wire               DISPLACEMENT_TYPE,
    input  wire               WAIT_UNIT_SELECT,
    input  wire               STAGE_WRITE,
    input  wire [3:0]         STAGE_WRITE_INDEX,
    input  wire [DISP_W-1:0]  STAGE_DISPLACEMENT,
    input  wire [SPEED_W-1:0] STAGE_SPEED,
    input  wire [TIME_W-1:0]  STAGE_RAMP,
    input  wire [TIME_W-1:0]  STAGE_WAIT,
    input  wire               SERVO_ON,
    input  wire               HOMING_START_INPUT,
    input  wire [3:0]         STAGE_SELECT_INPUTS,
    input  wire               ORIGIN_PROXIMITY_SWITCH,
    input  wire               ENCODER_INDEX,
    input  wire               MOTION_DONE,
    output reg  [SPEED_W-1:0] SPEED_CMD,
    output reg  [TIME_W-1:0]  RAMP_TIME,
    output reg                DIR_NEGATIVE,
    output reg                HOMING_ACTIVE,
    output reg  [DISP_W-1:0]  TARGET_POSITION,
    output reg                TARGET_ABSOLUTE,
    output reg                START_AT_PREV_SPEED,
    output reg                MOVE_START,
    output reg                STOP_NOW,
    output reg                HOMING_DONE,
    output reg                HOMING_TIMEOUT_ERROR,
    output reg  [3:0]         ACTIVE_STAGE
);
    // one-hot sequencer states
    localparam [7:0] S_IDLE   = 8'h01;   // waiting for homing or a run
    localparam [7:0] S_HFAST  = 8'h02;   // high speed search
    localparam [7:0] S_HDECEL = 8'h04;   // ramping to zero after reference edge
    localparam [7:0] S_HSLOW  = 8'h08;   // low speed reverse search
    localparam [7:0] S_FETCH  = 8'h10;   // reading the stage record
    localparam [7:0] S_MOVE   = 8'h20;   // stage move in progress
    localparam [7:0] S_WAIT   = 8'h40;   // inter-stage wait
    localparam [7:0] S_DONE   = 8'h80;   // program ended, hold until enable drops or position mode is left

    reg  [7:0]  state;          // current state
    reg         servo_prev;     // enable one cycle ago
    reg         start_prev;     // homing start input one cycle ago
    reg         ref_prev;       // homing reference one cycle ago
    reg         homed;          // the last search completed and homing has not been switched off or released since
    reg         auto_pending;   // auto homing not yet launched after power-up
    reg         post_go;        // run the program straight after homing
    reg         interrupted;    // program was cut by the enable dropping, leaving position mode or the origin going invalid
    reg  [3:0]  stage;          // stage being fetched or run
    reg         fetch_ready;    // record read data now valid
    reg         run_started;    // at least one stage moved in this run
    reg         home_tmr_start; // pulses to the timers
    reg         step_tmr_start;
    reg  [TIME_W-1:0] step_load;    // load for decel or wait timer
    reg               step_in_sec;  // step timer counts seconds

    wire [`REC_WIDTH-1:0] rec;      // stored stage record
    wire home_tmr_done;
    wire step_tmr_done;

    wire pos_mode   = (CONTROL_MODE_SELECT == `CTRL_MODE_POSITION);
    wire ref_level  = HOMING_SEARCH_MODE[`SEARCH_INDEX_BIT] ? ENCODER_INDEX : ORIGIN_PROXIMITY_SWITCH;
    wire ref_rise   = ref_level & ~ref_prev;
    wire ref_fall   = ~ref_level & ref_prev;
    wire servo_rise = SERVO_ON & ~servo_prev;
    wire start_rise = HOMING_START_INPUT & ~start_prev;
    wire homing_st  = |(state & (S_HFAST | S_HDECEL | S_HSLOW));
    wire running_st = |(state & (S_FETCH | S_MOVE | S_WAIT));

    // homing requests; a second search needs the start input to fall and rise again
    wire home_req = pos_mode & SERVO_ON &
                    (((HOMING_ENABLE_SELECT == `HOME_EN_INPUT) & start_rise) |
                     ((HOMING_ENABLE_SELECT == `HOME_EN_AUTO) & auto_pending));

    // stage commands count with homing off, else only once the origin is valid and, in input mode, the input holds
    wire homed_ok = (HOMING_ENABLE_SELECT == `HOME_EN_OFF) |
                    (homed & ((HOMING_ENABLE_SELECT != `HOME_EN_INPUT) | HOMING_START_INPUT));
    wire run_ok   = pos_mode & SERVO_ON & homed_ok;

    wire [3:0] last_stage = (EFFECTIVE_STAGES == 5'h00) ? `STAGE_FIRST : EFFECTIVE_STAGES[3:0] - 4'h1;
    wire       at_last    = (stage == last_stage);
    wire       mode_input = (STAGE_OPERATION_MODE == `OP_INPUT);

    // stage after n, wrapping to stage 1 past the last effective one
    function [3:0] stage_after;
        input [3:0] n;
        input [3:0] last;
        begin
            stage_after = (n == last) ? `STAGE_FIRST : n + 4'h1;
        end
    endfunction

    // the sixteen stored stage records
    stage_memory #(
        .DEPTH  (16),
        .ADDR_W (4),
        .WIDTH  (`REC_WIDTH)
    ) u_stage_memory (
        .clk   (CORE_CLK),
        .we    (STAGE_WRITE),
        .waddr (STAGE_WRITE_INDEX),
        .wdata ({STAGE_WAIT, STAGE_RAMP, STAGE_SPEED, STAGE_DISPLACEMENT}),
        .raddr (stage),
        .rdata (rec)
    );

    // homing timeout, always in milliseconds
    interval_timer #(
        .CYCLES_PER_MS (CYCLES_PER_MS),
        .TIME_W        (TIME_W)
    ) u_home_timer (
        .clk      (CORE_CLK),
        .reset    (RESET),
        .start    (home_tmr_start),
        .stop     (~homing_st),
        .load     (HOMING_TIMEOUT),
        .unit_sec (1'b0),
        .done     (home_tmr_done)
    );

    // deceleration time and inter-stage waits
    interval_timer #(
        .CYCLES_PER_MS (CYCLES_PER_MS),
        .TIME_W        (TIME_W)
    ) u_step_timer (
        .clk      (CORE_CLK),
        .reset    (RESET),
        .start    (step_tmr_start),
        .stop     (1'b0),
        .load     (step_load),
        .unit_sec (step_in_sec),
        .done     (step_tmr_done)
    );

    // edge history of the inputs
    always @(posedge CORE_CLK) begin
        if (RESET) begin
            servo_prev <= 1'b0;
            start_prev <= 1'b0;
            ref_prev   <= 1'b0;
        end else begin
            servo_prev <= SERVO_ON;
            start_prev <= HOMING_START_INPUT;
            ref_prev   <= ref_level;
        end
    end

    // main sequencer; every output is registered here
    always @(posedge CORE_CLK) begin
        if (RESET) begin
            state                <= S_IDLE;
            homed                <= 1'b0;
            auto_pending         <= 1'b1;
            post_go              <= 1'b0;
            interrupted          <= 1'b0;
            stage                <= `STAGE_FIRST;
            fetch_ready          <= 1'b0;
            run_started          <= 1'b0;
            home_tmr_start       <= 1'b0;
            step_tmr_start       <= 1'b0;
            step_load            <= {TIME_W{1'b0}};
            step_in_sec          <= 1'b0;
            SPEED_CMD            <= {SPEED_W{1'b0}};
            RAMP_TIME            <= {TIME_W{1'b0}};
            DIR_NEGATIVE         <= 1'b0;
            HOMING_ACTIVE        <= 1'b0;
            TARGET_POSITION      <= {DISP_W{1'b0}};
            TARGET_ABSOLUTE      <= 1'b0;
            START_AT_PREV_SPEED  <= 1'b0;
            MOVE_START           <= 1'b0;
            STOP_NOW             <= 1'b0;
            HOMING_DONE          <= 1'b0;
            HOMING_TIMEOUT_ERROR <= 1'b0;
            ACTIVE_STAGE         <= `STAGE_FIRST;
        end else begin
            // pulses default low
            MOVE_START     <= 1'b0;
            STOP_NOW       <= 1'b0;
            home_tmr_start <= 1'b0;
            step_tmr_start <= 1'b0;
            ACTIVE_STAGE   <= stage;
            if (homing_st & (~pos_mode | ~SERVO_ON)) begin
                // search abandoned: leaving position mode or losing the enable
                state         <= S_IDLE;
                HOMING_ACTIVE <= 1'b0;
                SPEED_CMD     <= {SPEED_W{1'b0}};
                STOP_NOW      <= 1'b1;
            end else if (homing_st & home_tmr_done) begin
                state                <= S_IDLE;
                HOMING_ACTIVE        <= 1'b0;
                SPEED_CMD            <= {SPEED_W{1'b0}};
                STOP_NOW             <= 1'b1;
                HOMING_TIMEOUT_ERROR <= 1'b1;
            end else if (running_st & ~run_ok) begin
                // enable lost, position mode left or origin invalid: halt and remember the stage
                state       <= S_IDLE;
                SPEED_CMD   <= {SPEED_W{1'b0}};
                STOP_NOW    <= 1'b1;
                interrupted <= 1'b1;
            end else begin
                case (state)
                    S_IDLE: begin
                        if (home_req) begin
                            state                <= S_HFAST;
                            auto_pending         <= 1'b0;
                            homed                <= 1'b0;
                            HOMING_DONE          <= 1'b0;
                            HOMING_TIMEOUT_ERROR <= 1'b0;
                            home_tmr_start       <= 1'b1;
                            HOMING_ACTIVE        <= 1'b1;
                            SPEED_CMD            <= HOMING_HIGH_SPEED;
                            RAMP_TIME            <= HOMING_DECEL_TIME;
                            DIR_NEGATIVE         <= HOMING_SEARCH_MODE[`SEARCH_NEG_BIT];
                            MOVE_START           <= 1'b1;
                        end else if (run_ok & servo_rise) begin
                            state       <= S_FETCH;
                            fetch_ready <= 1'b0;
                            run_started <= 1'b0;
                            post_go     <= 1'b0;
                            if (mode_input) begin
                                stage <= STAGE_SELECT_INPUTS;
                            end else if (interrupted & (RESIDUAL_COMMAND_MODE == `RESID_NEXT_STAGE)) begin
                                stage <= stage_after(stage, last_stage);
                            end else begin
                                stage <= `STAGE_FIRST;
                            end
                        end else if (run_ok & post_go) begin
                            state       <= S_FETCH;
                            fetch_ready <= 1'b0;
                            run_started <= 1'b0;
                            post_go     <= 1'b0;
                            stage       <= mode_input ? STAGE_SELECT_INPUTS : `STAGE_FIRST;
                        end
                    end
                    S_HFAST: begin
                        if (ref_rise) begin
                            state          <= S_HDECEL;
                            SPEED_CMD      <= {SPEED_W{1'b0}};
                            step_load      <= HOMING_DECEL_TIME;
                            step_in_sec    <= 1'b0;
                            step_tmr_start <= 1'b1;
                        end
                    end
                    S_HDECEL: begin
                        if (step_tmr_done) begin
                            state        <= S_HSLOW;
                            SPEED_CMD    <= HOMING_LOW_SPEED;
                            DIR_NEGATIVE <= ~HOMING_SEARCH_MODE[`SEARCH_NEG_BIT];
                            MOVE_START   <= 1'b1;
                        end
                    end
                    S_HSLOW: begin
                        if (ref_fall) begin
                            state         <= S_IDLE;
                            SPEED_CMD     <= {SPEED_W{1'b0}};
                            STOP_NOW      <= 1'b1;
                            HOMING_ACTIVE <= 1'b0;
                            HOMING_DONE   <= 1'b1;
                            homed         <= 1'b1;
                            interrupted   <= 1'b0;
                            post_go       <= (HOMING_POST_ACTION == `POST_RUN_NOW);
                        end
                    end
                    S_FETCH: begin
                        // memory read data arrive one edge after the index
                        fetch_ready <= 1'b1;
                        if (fetch_ready) begin
                            state               <= S_MOVE;
                            fetch_ready         <= 1'b0;
                            TARGET_POSITION     <= rec[`REC_DISP_LSB +: DISP_W];
                            TARGET_ABSOLUTE     <= DISPLACEMENT_TYPE;
                            SPEED_CMD           <= rec[`REC_SPEED_LSB +: SPEED_W];
                            RAMP_TIME           <= rec[`REC_RAMP_LSB +: TIME_W];
                            DIR_NEGATIVE        <= 1'b0;
                            START_AT_PREV_SPEED <= (STAGE_OPERATION_MODE == `OP_SEQUENCE) & run_started;
                            MOVE_START          <= 1'b1;
                            run_started         <= 1'b1;
                        end
                    end
                    S_MOVE: begin
                        if (MOTION_DONE) begin
                            if (mode_input | (at_last & (STAGE_OPERATION_MODE != `OP_CYCLIC))) begin
                                state       <= S_DONE;
                                interrupted <= 1'b0;
                                SPEED_CMD   <= {SPEED_W{1'b0}};
                            end else if (STAGE_OPERATION_MODE == `OP_SEQUENCE) begin
                                state <= S_FETCH;
                                stage <= stage_after(stage, last_stage);
                            end else begin
                                state          <= S_WAIT;
                                step_load      <= rec[`REC_WAIT_LSB +: TIME_W];
                                step_in_sec    <= (WAIT_UNIT_SELECT == `WAIT_UNIT_SEC);
                                step_tmr_start <= 1'b1;
                            end
                        end
                    end
                    S_WAIT: begin
                        if (step_tmr_done) begin
                            state <= S_FETCH;
                            stage <= stage_after(stage, last_stage);
                        end
                    end
                    S_DONE: begin
                        // a fresh run needs the enable to drop and return
                        if (~SERVO_ON | ~pos_mode) begin
                            state <= S_IDLE;
                        end
                    end
                    default: begin
                        state <= S_IDLE;
                    end
                endcase
            end
            // disabling homing or releasing the input drops completion
            if ((HOMING_ENABLE_SELECT == `HOME_EN_OFF) |
                ((HOMING_ENABLE_SELECT == `HOME_EN_INPUT) & ~HOMING_START_INPUT)) begin
                HOMING_DONE <= 1'b0;
                homed       <= 1'b0;
            end
        end
    end
endmodule // homing_and_multistage_position

// ==== design/homing_and_multistage_position_regs.vh ====
/*
  constants for the homing and multistage position sequencer: setting encodings,
  stage record layout and timing figures.
  assumes it is included by bare name from design files of this block.
*/
`ifndef HOMING_AND_MULTISTAGE_POSITION_REGS_VH
`define HOMING_AND_MULTISTAGE_POSITION_REGS_VH

// timing
`define CLK_PERIOD_NS        10
`define MS_PERIOD_NS         1000000
`define MS_PER_SEC           10'h3e8

// control mode selection value meaning position control
`define CTRL_MODE_POSITION   4'h0

// homing enable selection
`define HOME_EN_OFF          2'h0
`define HOME_EN_INPUT        2'h1
`define HOME_EN_AUTO         2'h2

// homing search mode bit positions
`define SEARCH_NEG_BIT       0
`define SEARCH_INDEX_BIT     1

// post-homing action
`define POST_RUN_NOW         1'b0

// residual command handling
`define RESID_NEXT_STAGE     1'b0

// stage operation modes
`define OP_SINGLE            2'h0
`define OP_CYCLIC            2'h1
`define OP_INPUT             2'h2
`define OP_SEQUENCE          2'h3

// wait unit selection
`define WAIT_UNIT_SEC        1'b1

// first stage index (stage 1)
`define STAGE_FIRST          4'h0

// stage record layout: {wait, ramp, speed, displacement}
`define REC_DISP_LSB         0
`define REC_SPEED_LSB        32
`define REC_RAMP_LSB         48
`define REC_WAIT_LSB         64
`define REC_WIDTH            80

`endif

// ==== design/interval_timer.v ====
/*
  millisecond based one-shot timer; counts a load value in ms or seconds and
  gives a one-cycle done pulse when it runs out.
  assumes a synchronous active high reset and a free running clock.
*/
`timescale 1ns/1ns
`include "homing_and_multistage_position_regs.vh"

module interval_timer #(
    parameter CYCLES_PER_MS = `MS_PERIOD_NS / `CLK_PERIOD_NS,
    parameter TIME_W        = 16
) (
    input  wire              clk,
    input  wire              reset,
    input  wire              start,
    input  wire              stop,
    input  wire [TIME_W-1:0] load,
    input  wire              unit_sec,
    output reg               done
);
    reg [31:0]       pre;    // cycle prescaler to one millisecond
    reg [9:0]        sub;    // ms within one second when counting seconds
    reg [TIME_W-1:0] left;   // units still to run
    reg              run;    // timer is counting

    wire ms_tick  = (pre == CYCLES_PER_MS - 1);
    wire unit_end = ms_tick & (~unit_sec | (sub == `MS_PER_SEC - 10'h001));

    // countdown; a zero load expires one cycle after start
    always @(posedge clk) begin
        done <= 1'b0;
        if (reset | stop) begin
            run  <= 1'b0;
            pre  <= 32'h0000_0000;
            sub  <= 10'h000;
            left <= {TIME_W{1'b0}};
        end else if (start) begin
            run  <= 1'b1;
            pre  <= 32'h0000_0000;
            sub  <= 10'h000;
            left <= load;
        end else if (run) begin
            if (left == {TIME_W{1'b0}}) begin
                run  <= 1'b0;
                done <= 1'b1;
            end else begin
                pre <= ms_tick ? 32'h0000_0000 : pre + 32'h0000_0001;
                if (ms_tick) begin
                    sub <= unit_end ? 10'h000 : sub + 10'h001;
                end
                if (unit_end) begin
                    left <= left - {{(TIME_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // interval_timer

// ==== design/stage_memory.v ====
/*
  holds the sixteen stored stage records; one write port, registered read.
  assumes the writer and reader share the core clock.
*/
`timescale 1ns/1ns
`include "homing_and_multistage_position_regs.vh"

module stage_memory #(
    parameter DEPTH  = 16,
    parameter ADDR_W = 4,
    parameter WIDTH  = `REC_WIDTH
) (
    input  wire              clk,
    input  wire              we,
    input  wire [ADDR_W-1:0] waddr,
    input  wire [WIDTH-1:0]  wdata,
    input  wire [ADDR_W-1:0] raddr,
    output reg  [WIDTH-1:0]  rdata
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];   // stage storage, no reset: contents come from setup

    // write and registered read; read data lags the address by one edge
    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule // stage_memory

// ==== tb/homing_props.sv ====
/* port checker for the homing and stage sequencer; assumes CYCLES_PER_MS of 10 and inputs that move at negedge */
`timescale 1ns/1ns
module homing_props (
    input wire        CORE_CLK,
    input wire        RESET,
    input wire [3:0]  CONTROL_MODE_SELECT,
    input wire [1:0]  HOMING_ENABLE_SELECT,
    input wire [1:0]  HOMING_SEARCH_MODE,
    input wire        HOMING_START_INPUT,
    input wire        SERVO_ON,
    input wire        DISPLACEMENT_TYPE,
    input wire        MOVE_START,
    input wire        STOP_NOW,
    input wire        DIR_NEGATIVE,
    input wire        HOMING_ACTIVE,
    input wire        HOMING_DONE,
    input wire        HOMING_TIMEOUT_ERROR,
    input wire        TARGET_ABSOLUTE,
    input wire [15:0] SPEED_CMD
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    // a search may only stand in position mode
    mode_gates_homing_a: assert property (CONTROL_MODE_SELECT != 4'h0 |=> !HOMING_ACTIVE) else $error("homing outside position mode");
    search_launch_a: assert property ($rose(HOMING_ACTIVE) |-> MOVE_START && DIR_NEGATIVE == HOMING_SEARCH_MODE[0]) else $error("bad search launch");
    done_stops_a: assert property ($rose(HOMING_DONE) |-> STOP_NOW && !HOMING_ACTIVE && SPEED_CMD == 16'h0000) else $error("done without stop");
    timeout_stops_a: assert property ($rose(HOMING_TIMEOUT_ERROR) |-> STOP_NOW && !HOMING_DONE) else $error("timeout without stop");
    homing_off_a: assert property (HOMING_ENABLE_SELECT == 2'h0 && !HOMING_ACTIVE |=> !HOMING_ACTIVE) else $error("search while off");
    unhomed_idle_a: assert property (HOMING_ENABLE_SELECT == 2'h1 && !HOMING_START_INPUT && !HOMING_ACTIVE |=> !MOVE_START) else $error("stage while unhomed");
    servo_off_stop_a: assert property ($fell(SERVO_ON) && HOMING_ACTIVE |-> ##[1:2] STOP_NOW) else $error("no stop on servo off");
    stage_fields_a: assert property (MOVE_START && !HOMING_ACTIVE |-> !DIR_NEGATIVE && TARGET_ABSOLUTE == DISPLACEMENT_TYPE) else $error("bad stage fields");
    done_clear_a: assert property (HOMING_ENABLE_SELECT == 2'h0 |=> !HOMING_DONE) else $error("done kept while off");
    cover property ($rose(HOMING_DONE));
    cover property ($rose(HOMING_TIMEOUT_ERROR));
    cover property (MOVE_START && !HOMING_ACTIVE);
endmodule // homing_props
bind homing_and_multistage_position homing_props homing_props_i (.*);

// ==== tb/motion_model.sv ====
/* profile generator stand-in: finishes each stage move four cycles after it starts; ignores homing moves */
`timescale 1ns/1ns
module motion_model (
    input wire clk,
    input wire move_start,
    input wire homing_active,
    output reg motion_done
);
    reg [2:0] pipe = 3'h0; // move age; no pulse input exists, motion only from stored stages
    initial motion_done = 1'b0;
    // delay line gives the sequencer a few cycles of real motion
    always @(posedge clk) begin
        pipe <= {pipe[1:0], move_start & ~homing_active};
        motion_done <= pipe[2];
    end
endmodule // motion_model

// ==== tb/tb.sv ====
/* self-checking bench for the sequencer; assumes CYCLES_PER_MS of 10 so one ms is ten clocks */
`timescale 1ns/1ns
module tb;
    reg CORE_CLK = 0, RESET = 1, HOMING_POST_ACTION = 1, RESIDUAL_COMMAND_MODE = 0, DISPLACEMENT_TYPE = 1;
    reg WAIT_UNIT_SELECT = 0, STAGE_WRITE = 0, SERVO_ON = 1, HOMING_START_INPUT = 0;
    reg ORIGIN_PROXIMITY_SWITCH = 0, ENCODER_INDEX = 0;
    reg [3:0] CONTROL_MODE_SELECT = 0, STAGE_WRITE_INDEX = 0, STAGE_SELECT_INPUTS = 0;
    reg [1:0] HOMING_ENABLE_SELECT = 1, HOMING_SEARCH_MODE = 0, STAGE_OPERATION_MODE = 0;
    reg [4:0] EFFECTIVE_STAGES = 5'h01;
    reg [15:0] HOMING_TIMEOUT = 16'h0064, STAGE_SPEED = 16'h0040;
    reg [31:0] STAGE_DISPLACEMENT = 32'h0000_1234;
    wire [15:0] HOMING_HIGH_SPEED = 16'h0100, HOMING_LOW_SPEED = 16'h0010, HOMING_DECEL_TIME = 16'h0001;
    wire [15:0] STAGE_RAMP = 16'h0002, STAGE_WAIT = 16'h0001, SPEED_CMD, RAMP_TIME;
    wire [31:0] TARGET_POSITION;
    wire [3:0] ACTIVE_STAGE;
    wire MOTION_DONE, DIR_NEGATIVE, HOMING_ACTIVE, TARGET_ABSOLUTE, START_AT_PREV_SPEED;
    wire MOVE_START, STOP_NOW, HOMING_DONE, HOMING_TIMEOUT_ERROR;
    integer miscompares = 0, comparisons = 0, n, t;
    reg [2:0] rows [0:3]; // search mode beside expected fast direction in bit 0
    homing_and_multistage_position #(.CYCLES_PER_MS(10)) homing_and_multistage_position_i (.*);
    motion_model motion_model_i (.clk(CORE_CLK), .move_start(MOVE_START), .homing_active(HOMING_ACTIVE),
                                 .motion_done(MOTION_DONE));
    always #5 CORE_CLK = ~CORE_CLK;
    task give_verdict;
        begin
            $display("comparisons %0d miscompares %0d", comparisons, miscompares);
            if (miscompares == 0 && comparisons > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("FAIL t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // bounded wait guard: a used-up bound ends the run
    task lim;
        if (n >= 300) begin
            miscompares = miscompares + 1;
            give_verdict;
        end
    endtask
    initial begin
        rows[0] = 3'b000; rows[1] = 3'b100; rows[2] = 3'b111; rows[3] = 3'b011;
        repeat (4) @(negedge CORE_CLK);
        RESET = 0;
        chk(HOMING_DONE, 0); chk(SPEED_CMD, 0);
        // host toggles the start input low then high to rehome each pass
        for (t = 0; t < 4; t = t + 1) begin
            HOMING_SEARCH_MODE = rows[t][2:1];
            HOMING_START_INPUT = 0; @(negedge CORE_CLK); HOMING_START_INPUT = 1;
            for (n = 0; n < 300 && HOMING_ACTIVE !== 1'b1; n = n + 1) @(negedge CORE_CLK); lim;
            chk(DIR_NEGATIVE, rows[t][0]); chk(SPEED_CMD, 16'h0100);
            {ENCODER_INDEX, ORIGIN_PROXIMITY_SWITCH} = HOMING_SEARCH_MODE[1] ? 2'b10 : 2'b01;
            for (n = 0; n < 300 && SPEED_CMD !== 16'h0010; n = n + 1) @(negedge CORE_CLK); lim;
            chk(DIR_NEGATIVE, !rows[t][0]);
            {ENCODER_INDEX, ORIGIN_PROXIMITY_SWITCH} = 2'b00;
            for (n = 0; n < 300 && HOMING_DONE !== 1'b1; n = n + 1) @(negedge CORE_CLK); lim;
            chk(HOMING_ACTIVE, 0); chk(HOMING_TIMEOUT_ERROR, 0);
            $display("homing row %0d done", t);
        end
        // no reference ever arrives: two ms timeout
        HOMING_TIMEOUT = 16'h0002; HOMING_START_INPUT = 0; @(negedge CORE_CLK); HOMING_START_INPUT = 1;
        for (n = 0; n < 300 && HOMING_TIMEOUT_ERROR !== 1'b1; n = n + 1) @(negedge CORE_CLK); lim;
        chk(n > 15, 1); chk(HOMING_DONE, 0); chk(HOMING_ACTIVE, 0);
        $display("timeout test done");
        // search cut by mode and enable
        HOMING_START_INPUT = 0; @(negedge CORE_CLK); HOMING_START_INPUT = 1; repeat (2) @(negedge CORE_CLK);
        chk(HOMING_ACTIVE, 1); CONTROL_MODE_SELECT = 1;
        // stage 1 with homing off, absolute target, single run
        HOMING_ENABLE_SELECT = 0; SERVO_ON = 0; STAGE_WRITE = 1; @(negedge CORE_CLK); STAGE_WRITE = 0;
        chk(STOP_NOW, 1); CONTROL_MODE_SELECT = 0; SERVO_ON = 1;
        for (n = 0; n < 300 && MOVE_START !== 1'b1; n = n + 1) @(negedge CORE_CLK); lim;
        chk(TARGET_POSITION, 32'h0000_1234); chk(TARGET_ABSOLUTE, 1); chk(HOMING_DONE, 0);
        @(negedge CORE_CLK); for (n = 0; n < 40 && MOVE_START !== 1'b1; n = n + 1) @(negedge CORE_CLK);
        chk(n, 40);
        $display("stage test done");
        give_verdict;
    end
endmodule // tb
